// File: hdl/rx_power_and_control_status_regs.sv
// Purpose: received-power result and control/status bytes behind a two-wire slave
// Assumes: scl/sda and module pins are asynchronous; converter is on ref_clk
// Notes:   sda is open drain; the pad is pulled low while sda_oe_b is low
`timescale 1ns/100ps
`include "rxpwr_regs.svh"

// Function
// - high and low bytes form one unsigned 16-bit result, high byte on top.
// - low byte count weighs 0.1 uW, high byte count 25.6 uW.
// - low byte never used for threshold or alarm comparison.
// - power bytes reset to zero, valid after one conversion cycle.
// - power bytes read-only at 104 and 105, device address 1010001b.
// - control/status byte at 110, resets to zero.
// - bit 7 read-only, follows transmit-disable pin.
// - bit 6 writable soft transmit disable, 1 disables.
// - bit 4 follows rate-select pin level.
// - bit 3 writable soft rate select, 1 high rate, 0 low.
// - bit 2 read-only, mirrors transmit-fault pin.
// - bit 1 read-only, mirrors loss-of-signal pin.
// - bit 0 reads 1 during power-on, 0 once data ready.
module rx_power_and_control_status_regs
  import rxpwr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe_b,
  input  wire logic        tx_off_input,
  input  wire logic        rate_pin_in,
  input  wire logic        tx_fault_output,
  input  wire logic        signal_lost_in,
  input  wire logic [15:0] conv_result,
  input  wire logic        conv_done,
  output      logic        tx_disable,
  output      logic        rate_high,
  output      logic [7:0]  rx_power_cmp_byte,
  output      logic        por_busy
);

  logic [1:0]  bus_f;
  logic [3:0]  pins_f;
  pin_view_t   pins;
  capture_t    cap;
  main_state_t s_q;
  main_state_t s_d;

  pin_sync #(
    .W    (2),
    .INIT (2'h3)
  ) u_bus_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  ({scl_in, sda_in}),
    .pin_out (bus_f)
  );

  pin_sync #(
    .W    (4),
    .INIT (4'h0)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  ({tx_off_input, rate_pin_in, tx_fault_output, signal_lost_in}),
    .pin_out (pins_f)
  );

  assign pins = pin_view_t'(pins_f);

  rx_power_capture u_capture (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .conv_result (conv_result),
    .conv_done   (conv_done),
    .cap         (cap)
  );

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] live_ctrl;
  logic [7:0] shifted;

  assign scl_f      = bus_f[1];
  assign sda_f      = bus_f[0];
  assign scl_rise   = scl_f & ~s_q.scl_p;
  assign scl_fall   = ~scl_f & s_q.scl_p;
  assign start_seen = scl_f & s_q.scl_p & s_q.sda_p & ~sda_f;
  assign stop_seen  = scl_f & s_q.scl_p & ~s_q.sda_p & sda_f;
  assign shifted    = {s_q.sh[6:0], sda_f};

  // the control/status byte as the host sees it
  always_comb
  begin
    live_ctrl                       = `RXP_RESET_BYTE;
    live_ctrl[`RXP_BIT_TX_OFF_PIN]  = pins.tx_off_pin_state;
    live_ctrl[`RXP_BIT_SOFT_TX_OFF] = s_q.soft_tx_off;
    live_ctrl[`RXP_BIT_RESERVED]    = 1'b0;
    live_ctrl[`RXP_BIT_RATE_PIN]    = pins.rate_pin_state;
    live_ctrl[`RXP_BIT_SOFT_RATE]   = s_q.soft_rate_choice;
    live_ctrl[`RXP_BIT_TX_FAULT]    = pins.tx_fault_state;
    live_ctrl[`RXP_BIT_SIG_LOST]    = pins.signal_lost_state;
    live_ctrl[`RXP_BIT_POR]         = cap.por_busy;
  end

  // read data for one byte address; unmapped addresses read zero since the
  // rest of the map lives in other blocks
  function automatic logic [7:0] read_byte(
    input logic [7:0]  addr,
    input logic [15:0] pwr,
    input logic [7:0]  lo_shadow,
    input logic        lo_hold,
    input logic [7:0]  ctrl
  );
    logic [7:0] val;
    val = `RXP_UNMAPPED_BYTE;
    unique case (addr)
      `RXP_OFS_PWR_HIGH: val = pwr[15:8];
      `RXP_OFS_PWR_LOW:  val = lo_hold ? lo_shadow : pwr[7:0];
      `RXP_OFS_CTRL:     val = ctrl;
      default:           val = `RXP_UNMAPPED_BYTE;
    endcase
    return val;
  endfunction : read_byte

  always_comb
  begin
    s_d           = s_q;
    s_d.scl_p     = scl_f;
    s_d.sda_p     = sda_f;
    s_d.ctrl_view = live_ctrl;
    s_d.sda_out   = 1'b0;
    // either source disables the laser; the pin still wins if software clears
    s_d.tx_off_out = pins.tx_off_pin_state | s_q.soft_tx_off;
    s_d.rate_out   = s_q.soft_rate_choice;
    // thresholds see only the high byte, the low byte is for compliance
    s_d.cmp_byte   = cap.rx_power[15:8];
    s_d.por_out    = cap.por_busy;

    if (stop_seen)
    begin
      s_d.st      = TW_IDLE;
      s_d.drive   = 1'b0;
      s_d.lo_hold = 1'b0;
    end
    else if (start_seen)
    begin
      // repeated start lands here too
      s_d.st    = TW_ADDR;
      s_d.cnt   = `RXP_CNT_ZERO;
      s_d.drive = 1'b0;
    end
    else
    begin
      unique case (s_q.st)
        TW_IDLE:
        begin
          s_d.drive = 1'b0;
        end
        TW_ADDR:
        begin
          if (scl_rise)
          begin
            s_d.sh  = shifted;
            s_d.cnt = s_q.cnt + `RXP_CNT_ONE;
          end
          else if (scl_fall && s_q.cnt == `RXP_BITS_PER_BYTE)
          begin
            if (s_q.sh[7:1] == `RXP_DEV_ADDR)
            begin
              s_d.rw    = s_q.sh[0];
              s_d.drive = 1'b1;
              s_d.st    = TW_AACK;
            end
            else
            begin
              s_d.st = TW_IDLE;
            end
          end
        end
        TW_AACK:
        begin
          if (scl_fall)
          begin
            s_d.cnt = `RXP_CNT_ZERO;
            if (s_q.rw)
            begin
              s_d.sh = read_byte(s_q.ptr, cap.rx_power, s_q.lo_shadow, s_q.lo_hold,
                                 s_q.ctrl_view);
              if (s_q.ptr == `RXP_OFS_PWR_HIGH)
              begin
                // freeze the low half so a pair read is coherent
                s_d.lo_shadow = cap.rx_power[7:0];
                s_d.lo_hold   = 1'b1;
              end
              s_d.ptr   = s_q.ptr + `RXP_PTR_STEP;
              s_d.drive = ~s_d.sh[7];
              s_d.st    = TW_SEND;
            end
            else
            begin
              s_d.first = 1'b1;
              s_d.drive = 1'b0;
              s_d.st    = TW_RECV;
            end
          end
        end
        TW_RECV:
        begin
          if (scl_rise)
          begin
            s_d.sh  = shifted;
            s_d.cnt = s_q.cnt + `RXP_CNT_ONE;
          end
          else if (scl_fall && s_q.cnt == `RXP_BITS_PER_BYTE)
          begin
            s_d.drive = 1'b1;
            s_d.st    = TW_WACK;
            if (s_q.first)
            begin
              s_d.ptr   = s_q.sh;
              s_d.first = 1'b0;
            end
            else
            begin
              // power bytes and mirrored bits ignore writes; bit 5 is dropped
              if (s_q.ptr == `RXP_OFS_CTRL)
              begin
                s_d.soft_tx_off      = s_q.sh[`RXP_BIT_SOFT_TX_OFF];
                s_d.soft_rate_choice = s_q.sh[`RXP_BIT_SOFT_RATE];
              end
              s_d.ptr = s_q.ptr + `RXP_PTR_STEP;
            end
          end
        end
        TW_WACK:
        begin
          if (scl_fall)
          begin
            s_d.drive = 1'b0;
            s_d.cnt   = `RXP_CNT_ZERO;
            s_d.st    = TW_RECV;
          end
        end
        TW_SEND:
        begin
          if (scl_fall)
          begin
            s_d.cnt = s_q.cnt + `RXP_CNT_ONE;
            if (s_q.cnt == `RXP_BITS_PER_BYTE - `RXP_CNT_ONE)
            begin
              s_d.drive = 1'b0;
              s_d.st    = TW_RACK;
            end
            else
            begin
              s_d.sh    = {s_q.sh[6:0], 1'b0};
              s_d.drive = ~s_q.sh[6];
            end
          end
        end
        TW_RACK:
        begin
          if (scl_rise && sda_f)
          begin
            // no acknowledge: host is done, wait for stop or start
            s_d.st = TW_IDLE;
          end
          else if (scl_fall)
          begin
            s_d.cnt = `RXP_CNT_ZERO;
            s_d.sh  = read_byte(s_q.ptr, cap.rx_power, s_q.lo_shadow, s_q.lo_hold,
                                s_q.ctrl_view);
            if (s_q.ptr == `RXP_OFS_PWR_LOW)
            begin
              s_d.lo_hold = 1'b0;
            end
            s_d.ptr   = s_q.ptr + `RXP_PTR_STEP;
            s_d.drive = ~s_d.sh[7];
            s_d.st    = TW_SEND;
          end
        end
        default:
        begin
          s_d.st    = TW_IDLE;
          s_d.drive = 1'b0;
        end
      endcase
    end
    // enable gets its own flop so no gate sits between register and pad
    s_d.sda_oe_b = ~s_d.drive;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s_q.st               <= TW_IDLE;
      s_q.cnt              <= `RXP_CNT_ZERO;
      s_q.sh               <= `RXP_RESET_BYTE;
      s_q.rw               <= 1'b0;
      s_q.ptr              <= `RXP_RESET_BYTE;
      s_q.first            <= 1'b0;
      s_q.drive            <= 1'b0;
      s_q.sda_oe_b         <= 1'b1;
      s_q.sda_out          <= 1'b0;
      s_q.scl_p            <= 1'b1;
      s_q.sda_p            <= 1'b1;
      s_q.soft_tx_off      <= 1'b0;
      s_q.soft_rate_choice <= 1'b0;
      s_q.lo_shadow        <= `RXP_RESET_BYTE;
      s_q.lo_hold          <= 1'b0;
      s_q.ctrl_view        <= `RXP_RESET_BYTE;
      s_q.tx_off_out       <= 1'b0;
      s_q.rate_out         <= 1'b0;
      s_q.cmp_byte         <= `RXP_RESET_BYTE;
      s_q.por_out          <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sda_out           = s_q.sda_out;
  assign sda_oe_b          = s_q.sda_oe_b;
  assign tx_disable        = s_q.tx_off_out;
  assign rate_high         = s_q.rate_out;
  assign rx_power_cmp_byte = s_q.cmp_byte;
  assign por_busy          = s_q.por_out;

endmodule : rx_power_and_control_status_regs

// File: hdl/rxpwr_regs.svh
// Purpose: constants of the received-power and control/status register slice
// Assumes: byte-wide registers on a two-wire serial management bus
// Notes:   weights are kept in nanowatts so they stay whole numbers
`ifndef RXPWR_REGS_SVH
`define RXPWR_REGS_SVH

`define RXP_DEV_ADDR        7'h51
`define RXP_OFS_PWR_HIGH    8'h68
`define RXP_OFS_PWR_LOW     8'h69
`define RXP_OFS_CTRL        8'h6e
`define RXP_RESET_BYTE      8'h00
`define RXP_RESET_WORD      16'h0000
`define RXP_UNMAPPED_BYTE   8'h00

`define RXP_BIT_TX_OFF_PIN  7
`define RXP_BIT_SOFT_TX_OFF 6
`define RXP_BIT_RESERVED    5
`define RXP_BIT_RATE_PIN    4
`define RXP_BIT_SOFT_RATE   3
`define RXP_BIT_TX_FAULT    2
`define RXP_BIT_SIG_LOST    1
`define RXP_BIT_POR         0

`define RXP_BITS_PER_BYTE   4'h8
`define RXP_CNT_ZERO        4'h0
`define RXP_CNT_ONE         4'h1
`define RXP_PTR_STEP        8'h01

// one count of the low byte is 0.1 uW, of the high byte 25.6 uW
`define RXP_LOW_LSB_NW      100
`define RXP_HIGH_LSB_NW     25600

`endif

// File: hdl/rxpwr_pkg.sv
// Purpose: types shared by the received-power register slice
// Assumes: rxpwr_regs.svh holds every number
// Notes:   state machine codes are one-hot
package rxpwr_pkg;

  typedef enum logic [6:0] {
    TW_IDLE = 7'h01,
    TW_ADDR = 7'h02,
    TW_AACK = 7'h04,
    TW_RECV = 7'h08,
    TW_WACK = 7'h10,
    TW_SEND = 7'h20,
    TW_RACK = 7'h40
  } tw_state_t;

  // module pins mirrored into the control/status byte
  typedef struct packed {
    logic tx_off_pin_state;
    logic rate_pin_state;
    logic tx_fault_state;
    logic signal_lost_state;
  } pin_view_t;

  typedef struct packed {
    logic [15:0] rx_power;
    logic        por_started;
    logic        por_busy;
  } capture_t;

  typedef struct packed {
    tw_state_t   st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic [7:0]  ptr;
    logic        first;
    logic        drive;
    logic        sda_oe_b;
    logic        sda_out;
    logic        scl_p;
    logic        sda_p;
    logic        soft_tx_off;
    logic        soft_rate_choice;
    logic [7:0]  lo_shadow;
    logic        lo_hold;
    logic [7:0]  ctrl_view;
    logic        tx_off_out;
    logic        rate_out;
    logic [7:0]  cmp_byte;
    logic        por_out;
  } main_state_t;

endpackage : rxpwr_pkg

// File: hdl/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for async pins
// Assumes: inputs come from outside the ref_clk domain
// Notes:   output changes only once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic [W-1:0]  pin_in,
  output      logic [W-1:0]  pin_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } sync_state_t;

  sync_state_t  st_q;
  sync_state_t  st_d;
  logic [W-1:0] filt_d;

  // stage one feeds stage two only; the filter looks at two and three
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign filt_d[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.filt[i];
  end

  always_comb
  begin
    st_d      = st_q;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.filt = filt_d;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, filt: INIT};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pin_out = st_q.filt;

endmodule : pin_sync

// File: hdl/rx_power_capture.sv
// Purpose: holds the latest received-power conversion and power-on status
// Assumes: conv_done is a one-cycle pulse on ref_clk with conv_result valid
// Notes:   power-on status rises the cycle after reset release
`timescale 1ns/100ps
`include "rxpwr_regs.svh"
module rx_power_capture
  import rxpwr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] conv_result,
  input  wire logic        conv_done,
  output      capture_t    cap
);

  capture_t cap_q;
  capture_t cap_d;

  always_comb
  begin
    cap_d             = cap_q;
    cap_d.por_started = 1'b1;
    // power-on runs from release until the first conversion lands
    if (!cap_q.por_started)
    begin
      cap_d.por_busy = 1'b1;
    end
    if (conv_done)
    begin
      cap_d.rx_power = conv_result;
      cap_d.por_busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cap_q <= '{rx_power: `RXP_RESET_WORD, por_started: 1'b0, por_busy: 1'b0};
    end
    else
    begin
      cap_q <= cap_d;
    end
  end

  assign cap = cap_q;

endmodule : rx_power_capture

// File: bench/rxpwr_asserts.sv
// Purpose: concurrent checks on the register slice ports
// Assumes: pins and converter stay quiet while reset is low
// Notes:   pin and converter lags are taken as under eight cycles
`timescale 1ns/100ps
module rxpwr_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_b,
  input wire logic        tx_off_input,
  input wire logic        rate_pin_in,
  input wire logic        tx_fault_output,
  input wire logic        signal_lost_in,
  input wire logic [15:0] conv_result,
  input wire logic        conv_done,
  input wire logic        tx_disable,
  input wire logic        rate_high,
  input wire logic [7:0]  rx_power_cmp_byte,
  input wire logic        por_busy
);
  logic [7:0] hi_q;

  // last high byte handed over by the converter
  always_ff @(posedge ref_clk)
  begin
    if (conv_done)
      hi_q <= conv_result[15:8];
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_reset_vals: assert property ($rose(rst_b) |-> !tx_disable && !rate_high
    && rx_power_cmp_byte == 8'h00 && sda_oe_b) else $error("outputs not at reset values");
  a_por_rise: assert property ($rose(rst_b) |-> ##[1:5] por_busy)
    else $error("power-on status not raised after reset");
  a_por_clear: assert property (conv_done |-> ##[1:4] !por_busy)
    else $error("power-on status not cleared by conversion");
  a_cmp_follow: assert property (conv_done |=> ##[0:2] rx_power_cmp_byte == hi_q)
    else $error("compare byte is not the high byte");
  a_cmp_hold: assert property (!conv_done [*8] |-> $stable(rx_power_cmp_byte))
    else $error("compare byte moved without a conversion");
  a_tx_off_pin_state_pin: assert property (tx_off_input [*8] |-> tx_disable)
    else $error("transmitter not disabled by pin");
  a_sda_only_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property (scl_in [*8] |-> $stable(sda_oe_b))
    else $error("data pin changed while clock high");
endmodule : rxpwr_asserts

bind rx_power_and_control_status_regs rxpwr_asserts u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_b(sda_oe_b), .tx_off_input(tx_off_input), .rate_pin_in(rate_pin_in),
  .tx_fault_output(tx_fault_output), .signal_lost_in(signal_lost_in),
  .conv_result(conv_result), .conv_done(conv_done), .tx_disable(tx_disable),
  .rate_high(rate_high), .rx_power_cmp_byte(rx_power_cmp_byte), .por_busy(por_busy)
);

// File: bench/host_twowire.sv
// Purpose: host side of the two-wire management bus
// Assumes: data line has a pull-up; bus clock high for 12 clocks and low for 24 per bit
// Notes:   host moves the data line mid low phase of the bus clock, except for start and stop
`timescale 1ns/100ps
module host_twowire (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output      logic scl,
  output      logic sda_drv
);
  localparam int HALF = 12;

  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // also serves as a repeated start
  task automatic start_cond;
    sda_drv <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_drv <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask : start_cond

  task automatic stop_cond;
    sda_drv <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_drv <= 1'b1;
    tick(2 * HALF);
  endtask : stop_cond

  task automatic bit_xfer(input logic b, output logic r);
    sda_drv <= b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    r = sda_line;
    scl <= 1'b0;
    tick(HALF);
  endtask : bit_xfer

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      b[i] = r;
    end
    bit_xfer(last, r);
  endtask : get_byte

  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat,
                    output logic ack);
    logic a0, a1, a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start_cond;
    put_byte({dev, 1'b0}, a0);
    if (a0)
    begin
      put_byte(ptr, a1);
      put_byte(dat & 8'hdf, a2);
    end
    stop_cond;
    ack = a0 & a1 & a2;
  endtask : wr

  // two-byte read from ptr at the slice's bus address
  task automatic rd(input logic [7:0] ptr, output logic [7:0] b0, output logic [7:0] b1);
    logic a;
    start_cond;
    put_byte({7'h51, 1'b0}, a);
    put_byte(ptr, a);
    start_cond;
    put_byte({7'h51, 1'b1}, a);
    get_byte(1'b0, b0);
    get_byte(1'b1, b1);
    stop_cond;
  endtask : rd
endmodule : host_twowire

// File: bench/tb_top.sv
// Purpose: self-checking bench for the received-power register slice
// Assumes: reference values kept in plain integers in the bench
// Notes:   pins walked with pseudo-random values, soft bits through all four combinations
`timescale 1ns/100ps
module tb_top;
  import rxpwr_pkg::*;
  logic        ref_clk, rst_b, conv_done, tx_off, rate_pin, fault, lost;
  logic        sda_out, sda_oe_b, tx_disable, rate_high, por_busy, scl, sda_drv, ack;
  logic [15:0] conv_result, seed;
  logic [7:0]  cmp_byte, b0, b1, wdat;
  wire         sda_line = sda_drv & (sda_oe_b | sda_out);
  int          n_mismatch, check_count, cyc, m_pwr, m_por, s6, s3;
  int          q_pwr[$];

  rx_power_and_control_status_regs u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_b(sda_oe_b), .tx_off_input(tx_off), .rate_pin_in(rate_pin),
    .tx_fault_output(fault), .signal_lost_in(lost), .conv_result(conv_result),
    .conv_done(conv_done), .tx_disable(tx_disable), .rate_high(rate_high),
    .rx_power_cmp_byte(cmp_byte), .por_busy(por_busy)
  );
  host_twowire u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ceiling well above the roughly 35k cycles the sequence needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      finish_test;
    end
  end

  initial
  begin
    {rst_b, conv_done, tx_off, rate_pin, fault, lost} = '0;
    conv_result = 16'h0000;
    seed = 16'd71;
    m_por = 1;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("por_busy", 1, por_busy);
    u_host.rd(8'h68, b0, b1);
    chk("power high", 0, b0);
    chk("power low", 0, b1);
    u_host.rd(8'h6e, b0, b1);
    chk("control", 1, b0);
    chk("unmapped", 0, b1);
    u_host.wr(7'h50, 8'h6e, 8'h48, ack);
    chk("foreign address ack", 0, ack);
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr_next(seed);
      conv_result <= seed;
      conv_done <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      q_pwr.push_back(int'(seed));
      m_pwr = q_pwr.pop_front();
      m_por = 0;
      repeat (4) @(posedge ref_clk);
      chk("compare byte", m_pwr[15:8], cmp_byte);
      chk("por_busy", m_por, por_busy);
      u_host.wr(7'h51, 8'h68 + k[0], ~seed[7:0], ack);
      chk("write ack", 1, ack);
      u_host.rd(8'h68, b0, b1);
      chk("power word", m_pwr, {b0, b1});
      // host scales raw counts itself, in nanowatts
      chk("power nW", m_pwr * 100, b0 * 25600 + b1 * 100);
    end
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr_next(seed);
      {tx_off, rate_pin, fault, lost} <= seed[11:8];
      s6 = k % 2;
      s3 = k / 2 % 2;
      wdat = {seed[7], s6[0], 1'b0, seed[4], s3[0], seed[2:0]};
      u_host.wr(7'h51, 8'h6e, wdat, ack);
      chk("tx_disable", tx_off | s6[0], tx_disable);
      chk("rate_high", s3, rate_high);
      u_host.rd(8'h6e, b0, b1);
      chk("control", {tx_off, s6[0], 1'b0, rate_pin, s3[0], fault, lost, m_por[0]}, b0);
    end
    finish_test;
  end
endmodule : tb_top
